// ==== verilog/mlk_pkg.sv ====
`default_nettype none
package mlk_pkg;

    // ****************************************
    // Frame layout and fixed codes
    // ****************************************
    localparam int CMD_MAX_BITS = 30;
    localparam logic [4:0] READ_LEN = 5'h0e;
    localparam logic [4:0] WRITE_LEN = 5'h1e;
    localparam logic [5:0] SPECIAL_ADDR = 6'h3f;
    localparam logic [15:0] ACCESS_VALUE = 16'h62d2;
    localparam logic [2:0] CRC_INIT = 3'h7;
    localparam logic [2:0] CRC_GOOD = 3'h0;
    localparam logic [4:0] RESP_SYNC_BITS = 5'h02;
    localparam logic [4:0] RESP_CRC_FIRST = 5'h1a;
    localparam logic [4:0] RESP_LAST_BIT = 5'h1c;
    localparam int RESP_PAYLOAD_BITS = 24;

    // ****************************************
    // Timing and reset values
    // ****************************************
    localparam int HALF_WIDTH = 16;
    localparam logic [15:0] HALF_MIN = 16'h0002;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [1:0] ID_RESET = 2'h0;

    // ****************************************
    // Carriers and state types
    // ****************************************
    typedef struct packed {
        logic rw;
        logic [3:0] target;
        logic [5:0] addr;
        logic [15:0] data;
    } mlk_cmd_type;

    typedef struct packed {
        logic [1:0] id;
        logic bc;
        logic ae;
        logic ovr;
        logic cs;
        logic [15:0] data;
    } mlk_resp_type;

    typedef enum logic [2:0] {RX_IDLE, RX_MEASURE, RX_SYNC2, RX_BITS, RX_DONE} mlk_rx_state_type;
    typedef enum logic [1:0] {RS_IDLE, RS_WAIT, RS_SEND} mlk_rs_state_type;

    // One step of the x^3+x+1 check register, message bit fed in MSB first.
    function automatic logic [2:0] mlk_crc_step(input logic [2:0] crc, input logic din);
        logic c0;
        c0 = crc[2] ^ din;
        return {crc[1], crc[0] ^ c0, c0};
    endfunction

endpackage
`default_nettype wire

// ==== verilog/mlk_crc3.sv ====
`timescale 1ns/10ps
`default_nettype none
module mlk_crc3
    import mlk_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic clear, // Reload the all-ones start value.
    input wire logic shift, // Feed one bit.
    input wire logic din, // Bit to feed.
    output logic [2:0] crc // Running remainder.
);

    // ****************************************
    // Check register
    // ****************************************
    // Feeding the received check bits after the message leaves zero when they match.
    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            crc <= CRC_INIT;
        end else if (shift) begin
            crc <= mlk_crc_step(crc, din);
        end
    end

endmodule
`default_nettype wire

// ==== verilog/mlk_tx.sv ====
`timescale 1ns/10ps
`default_nettype none
module mlk_tx
    import mlk_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic start, // Begin a response frame.
    input wire logic [15:0] halfT, // Half bit time in clock cycles.
    input wire mlk_resp_type payload, // Identity, flags and data.
    output logic lineLow, // Pull the response line low.
    output logic busy // Frame in progress.
);

    logic [4:0] bitIdx;
    logic phase;
    logic [15:0] cnt;
    logic [23:0] shiftReg;
    logic [2:0] crc;
    logic [4:0] next_bitIdx;
    logic next_phase;
    logic [15:0] next_cnt;
    logic [23:0] next_shift;
    logic [2:0] next_crc;
    logic next_busy;
    logic [1:0] crcSel;
    wire cellEnd = (cnt == halfT - 16'h0001);
    wire inPayload = (bitIdx >= RESP_SYNC_BITS) && (bitIdx < RESP_CRC_FIRST);

    // ****************************************
    // Sequencing of cells and halves
    // ****************************************
    // Payload bits are folded into the check value as they leave, so no second pass is needed.
    always_comb begin
        next_bitIdx = bitIdx;
        next_phase = phase;
        next_cnt = cnt;
        next_shift = shiftReg;
        next_crc = crc;
        next_busy = busy;
        if (start && !busy) begin
            next_busy = 1'b1;
            next_bitIdx = 5'h00;
            next_phase = 1'b0;
            next_cnt = 16'h0000;
            next_shift = payload;
            next_crc = CRC_INIT;
        end else if (busy) begin
            if (cellEnd) begin
                next_cnt = 16'h0000;
                if (!phase) begin
                    next_phase = 1'b1;
                end else if (bitIdx == RESP_LAST_BIT) begin
                    next_busy = 1'b0;
                end else begin
                    next_phase = 1'b0;
                    next_bitIdx = bitIdx + 5'h01;
                    if (inPayload) begin
                        next_crc = mlk_crc_step(crc, shiftReg[23]);
                        next_shift = {shiftReg[22:0], 1'b0};
                    end
                end
            end else begin
                next_cnt = cnt + 16'h0001;
            end
        end
    end

    // Sync zeros, then payload MSB first, then check bits C2 first.
    assign crcSel = 2'(RESP_LAST_BIT - next_bitIdx);
    wire nextBit = (next_bitIdx < RESP_SYNC_BITS) ? 1'b0 :
        (next_bitIdx < RESP_CRC_FIRST) ? next_shift[23] : next_crc[crcSel];
    // A one is high then low, a zero low then high.
    wire next_lineLow = next_busy && (next_phase ? nextBit : !nextBit);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bitIdx <= 5'h00;
            phase <= 1'b0;
            cnt <= 16'h0000;
            shiftReg <= 24'h000000;
            crc <= CRC_INIT;
            busy <= 1'b0;
            lineLow <= 1'b0;
        end else begin
            bitIdx <= next_bitIdx;
            phase <= next_phase;
            cnt <= next_cnt;
            shiftReg <= next_shift;
            crc <= next_crc;
            busy <= next_busy;
            lineLow <= next_lineLow;
        end
    end

endmodule
`default_nettype wire

// ==== verilog/mlk_link.sv ====
// Behaviour
// - One mid-cell edge: falling one, rising zero.
// - Two zero sync bits start and time frames.
// - Accept when own selector bit is set.
// - All-zero selector means broadcast to all.
// - Identity from data-in and chip-select pin levels.
// - Valid addressed read returns a response frame.
// - Response identity is pin identity, zero if broadcast.
// - Broadcast flag for zero selector or SPI mode.
// - Abort flag when frame breaks after sync.
// - Overrun flag when command completes during response.
// - Checksum flag after a bad check value.
// - No read answers before the access code.
// - Access code ignores selector, enters serial mode.
// - Access: write, address ones, fixed access value.
// - Address ones with other data exits mode.
// - Read has no data; address picks returned register.
// - Every command ends with a checked 3-bit value.
// - Check: x^3+x+1, preset ones, MSB first.
// - Response: sync, identity, four flags, data, check.
// - Flags held until reported, then cleared.
// - Respond at the rate measured from sync.
`timescale 1ns/10ps
`default_nettype none
module mlk_link
    import mlk_pkg::*;
(
    input wire logic clk, // System clock, 100 MHz.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic supplyIn, // Decoded supply line level, high when idle.
    input wire logic dataInPin, // Data-in pin level, upper identity bit.
    input wire logic chipSelectPin, // Chip-select pin level, lower identity bit.
    input wire logic spiModeActive, // SPI interface mode is active.
    input wire logic linkDisable, // Ignore commands that start on the supply line while set.
    input wire logic [15:0] regReadData, // Register contents for the last read strobe.
    output logic regReadStrobe, // One-cycle read request.
    output logic regWriteStrobe, // One-cycle write request.
    output logic [5:0] regAddr, // Register address for either strobe.
    output logic [15:0] regWriteData, // Data for a write.
    output logic commMode, // Serial communication mode entered.
    output logic pwmOut, // Response pin output value, always low.
    output logic pwmOe_n // Response pin enable, low while pulling low.
);

    // ****************************************
    // Declarations
    // ****************************************
    mlk_rx_state_type rxState;
    mlk_rs_state_type rsState;
    logic linePrev;
    logic [15:0] cnt;
    logic [15:0] halfT;
    logic [4:0] bitCnt;
    logic rwBit;
    logic [CMD_MAX_BITS-1:0] cmdShift;
    logic [1:0] dieId;
    logic aeFlag;
    logic ovrFlag;
    logic csFlag;
    logic respBc;
    logic [15:0] waitCnt;
    logic [15:0] respHalf;
    logic txStart;
    mlk_resp_type txPayload;
    logic txLineLow;
    logic txBusy;
    logic [2:0] rxCrc;
    logic crcClear;
    logic crcShift;
    mlk_cmd_type cmd;

    // Returns true when the selector picks this die or addresses all dies.
    function automatic logic isSelected(input logic [3:0] target, input logic [1:0] id);
        return (target == 4'h0) || target[id];
    endfunction

    // ****************************************
    // Edge and window decoding
    // ****************************************
    // The window opens at three quarters of a bit after the last mid-cell edge, so boundary
    // edges between equal bits fall before it and are ignored.
    wire rise = supplyIn && !linePrev;
    wire fall = !supplyIn && linePrev;
    wire edgeSeen = rise || fall;
    wire [16:0] winStart = {1'b0, halfT} + {2'b00, halfT[15:1]};
    wire [17:0] tmoLimit = {1'b0, halfT, 1'b0} + {3'b000, halfT[15:1]};
    wire winOpen = {1'b0, cnt} >= winStart;
    wire timedOut = ({2'b00, cnt} >= tmoLimit) || (cnt == CNT_MAX);
    wire midEdge = edgeSeen && winOpen;
    wire [15:0] cntInc = (cnt == CNT_MAX) ? cnt : cnt + 16'h0001;
    wire [15:0] measured = cnt + 16'h0001;
    // The direction bit, known from the first field bit, fixes the frame length.
    wire curRw = (bitCnt == 5'h00) ? fall : rwBit;
    wire [4:0] expectLen = curRw ? READ_LEN : WRITE_LEN;
    wire lastBit = (bitCnt + 5'h01) == expectLen;

    // ****************************************
    // Command field decoding
    // ****************************************
    // A read frame sits in the low 14 bits, a write frame fills all 30.
    // Bits beyond the expected length are not kept; they begin a spurious new frame.
    always_comb begin
        if (rwBit) begin
            cmd.rw = cmdShift[13];
            cmd.target = cmdShift[12:9];
            cmd.addr = cmdShift[8:3];
            cmd.data = 16'h0000;
        end else begin
            cmd.rw = cmdShift[29];
            cmd.target = cmdShift[28:25];
            cmd.addr = cmdShift[24:19];
            cmd.data = cmdShift[18:3];
        end
    end

    wire crcOk = (rxCrc == CRC_GOOD);
    wire frameDone = (rxState == RX_DONE);
    // Mode codes act on any frame that passed its check, whatever the mode or selector.
    wire codeOk = frameDone && crcOk;
    wire specialCode = !cmd.rw && (cmd.addr == SPECIAL_ADDR);
    wire isAccess = specialCode && (cmd.data == ACCESS_VALUE);
    wire isExit = specialCode && (cmd.data != ACCESS_VALUE);
    wire selected = isSelected(cmd.target, dieId);
    wire acceptCmd = frameDone && crcOk && commMode && selected && !specialCode;
    wire respBusy = (rsState != RS_IDLE);
    // Reads arriving while an answer is still going out are dropped; the overrun flag tells why.
    wire startRead = acceptCmd && cmd.rw && !respBusy;
    wire doWrite = acceptCmd && !cmd.rw;
    wire abortEvt = (rxState == RX_BITS) && timedOut && !midEdge;
    wire ovrEvt = frameDone && respBusy;
    wire csEvt = frameDone && !crcOk;
    wire waitDone = (waitCnt == respHalf - 16'h0001);
    wire flagsTaken = (rsState == RS_WAIT) && waitDone;

    // The check register is held at its start value for as long as the second sync bit is awaited.
    assign crcClear = (rxState == RX_SYNC2);
    assign crcShift = (rxState == RX_BITS) && midEdge;

    mlk_crc3 u_crc (
        .clk(clk),
        .rst_n(rst_n),
        .clear(crcClear),
        .shift(crcShift),
        .din(fall),
        .crc(rxCrc)
    );

    // ****************************************
    // Receive state machine
    // ****************************************
    // The first low half gives the bit rate; the second zero must rise inside the window.
    // A first low half under two cycles is taken for a supply glitch and dropped.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxState <= RX_IDLE;
            cnt <= 16'h0000;
            halfT <= HALF_MIN;
            bitCnt <= 5'h00;
            rwBit <= 1'b0;
            cmdShift <= '0;
        end else begin
            case (rxState)
                RX_IDLE: begin
                    cnt <= 16'h0000;
                    if (fall && !linkDisable) begin
                        rxState <= RX_MEASURE;
                    end
                end
                RX_MEASURE: begin
                    cnt <= cntInc;
                    if (rise) begin
                        cnt <= 16'h0000;
                        halfT <= measured;
                        rxState <= (measured >= HALF_MIN) ? RX_SYNC2 : RX_IDLE;
                    end else if (cnt == CNT_MAX) begin
                        rxState <= RX_IDLE;
                    end
                end
                RX_SYNC2: begin
                    cnt <= cntInc;
                    if (midEdge) begin
                        cnt <= 16'h0000;
                        bitCnt <= 5'h00;
                        rxState <= rise ? RX_BITS : RX_IDLE;
                    end else if (timedOut) begin
                        rxState <= RX_IDLE;
                    end
                end
                RX_BITS: begin
                    cnt <= cntInc;
                    if (midEdge) begin
                        cnt <= 16'h0000;
                        cmdShift <= {cmdShift[CMD_MAX_BITS-2:0], fall};
                        bitCnt <= bitCnt + 5'h01;
                        rwBit <= curRw;
                        if (lastBit) begin
                            rxState <= RX_DONE;
                        end
                    end else if (timedOut) begin
                        rxState <= RX_IDLE;
                    end
                end
                RX_DONE: begin
                    rxState <= RX_IDLE;
                end
                default: begin
                    rxState <= RX_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Mode, identity and register strobes
    // ****************************************
    // The pins are re-read every cycle so the identity follows the board straps after reset.
    // A strap that moves mid-frame changes the selection of the frame in flight.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            linePrev <= 1'b1;
            dieId <= ID_RESET;
            commMode <= 1'b0;
            regReadStrobe <= 1'b0;
            regWriteStrobe <= 1'b0;
            regAddr <= 6'h00;
            regWriteData <= 16'h0000;
        end else begin
            linePrev <= supplyIn;
            dieId <= {dataInPin, chipSelectPin};
            if (codeOk && isAccess) begin
                commMode <= 1'b1;
            end else if (codeOk && isExit) begin
                commMode <= 1'b0;
            end
            regReadStrobe <= startRead;
            regWriteStrobe <= doWrite;
            if (startRead || doWrite) begin
                regAddr <= cmd.addr;
                regWriteData <= cmd.data;
            end
        end
    end

    // ****************************************
    // Sticky error flags
    // ****************************************
    // A new event in the cycle the flags are reported wins over the clear.
    // Flags are copied into the payload in the clearing cycle, so none is lost.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aeFlag <= 1'b0;
            ovrFlag <= 1'b0;
            csFlag <= 1'b0;
        end else begin
            aeFlag <= (aeFlag && !flagsTaken) || abortEvt;
            ovrFlag <= (ovrFlag && !flagsTaken) || ovrEvt;
            csFlag <= (csFlag && !flagsTaken) || csEvt;
        end
    end

    // ****************************************
    // Response sequencing
    // ****************************************
    // The answer waits half a bit so it begins at the end of the command's last cell.
    // The rate is latched with the read, so a command during the answer cannot alter its pace.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsState <= RS_IDLE;
            waitCnt <= 16'h0000;
            respHalf <= HALF_MIN;
            respBc <= 1'b0;
            txStart <= 1'b0;
            txPayload <= '0;
        end else begin
            txStart <= 1'b0;
            case (rsState)
                RS_IDLE: begin
                    waitCnt <= 16'h0000;
                    if (startRead) begin
                        respBc <= (cmd.target == 4'h0) || spiModeActive;
                        respHalf <= halfT;
                        rsState <= RS_WAIT;
                    end
                end
                RS_WAIT: begin
                    waitCnt <= waitCnt + 16'h0001;
                    if (waitDone) begin
                        txPayload.id <= respBc ? 2'h0 : dieId;
                        txPayload.bc <= respBc;
                        txPayload.ae <= aeFlag;
                        txPayload.ovr <= ovrFlag;
                        txPayload.cs <= csFlag;
                        txPayload.data <= regReadData;
                        txStart <= 1'b1;
                        rsState <= RS_SEND;
                    end
                end
                RS_SEND: begin
                    if (!txStart && !txBusy) begin
                        rsState <= RS_IDLE;
                    end
                end
                default: begin
                    rsState <= RS_IDLE;
                end
            endcase
        end
    end

    // The transmitter reuses the half bit time measured on the command.
    mlk_tx u_tx (
        .clk(clk),
        .rst_n(rst_n),
        .start(txStart),
        .halfT(respHalf),
        .payload(txPayload),
        .lineLow(txLineLow),
        .busy(txBusy)
    );

    // ****************************************
    // Open-drain response pin
    // ****************************************
    // The pin only ever pulls low; the pull-up gives the high level.
    // Releasing rather than driving high lets several dies share one wire.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwmOut <= 1'b0;
            pwmOe_n <= 1'b1;
        end else begin
            pwmOut <= 1'b0;
            pwmOe_n <= !txLineLow;
        end
    end

endmodule
`default_nettype wire

// ==== sim/mlk_link_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********
// Port checks of the link
// ********
module mlk_link_properties
    import mlk_pkg::*;
(
    input wire logic clk, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic regReadStrobe, // Read request.
    input wire logic regWriteStrobe, // Write request.
    input wire logic [5:0] regAddr, // Register address.
    input wire logic commMode, // Serial mode.
    input wire logic pwmOut, // Pin value.
    input wire logic pwmOe_n // Pin enable, low drives.
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A read is one pulse; the answer waits at least a half cell, so the pin stays released first.
    sequence rdPulse;
        regReadStrobe ##1 !regReadStrobe;
    endsequence
    sequence lineHeld;
        pwmOe_n [*4];
    endsequence
    read_pulse_a: assert property (regReadStrobe |-> rdPulse)
        else $error("read strobe too long");
    read_answer_a: assert property (regReadStrobe |-> lineHeld ##[1:300] !pwmOe_n)
        else $error("read got no timely answer");
    write_pulse_a: assert property (regWriteStrobe |=> !regWriteStrobe)
        else $error("write strobe too long");
    one_strobe_a: assert property (!(regReadStrobe && regWriteStrobe))
        else $error("both strobes at once");
    read_mode_a: assert property (regReadStrobe |-> commMode)
        else $error("read outside serial mode");
    write_mode_a: assert property (regWriteStrobe |-> commMode)
        else $error("write outside serial mode");
    code_write_a: assert property (regWriteStrobe |-> regAddr != SPECIAL_ADDR)
        else $error("mode code reached the registers");
    addr_hold_a: assert property (!$stable(regAddr) |-> regReadStrobe || regWriteStrobe)
        else $error("address moved without a strobe");
    half_cell_a: assert property ($fell(pwmOe_n) |-> !pwmOe_n [*2])
        else $error("low half cell too short");
    open_drain_a: assert property (pwmOut == 1'b0)
        else $error("pin driven high");
    reset_idle_a: assert property (disable iff (1'b0) !rst_n |=> pwmOe_n && !commMode && !regReadStrobe)
        else $error("outputs not idle after reset");
endmodule
bind mlk_link mlk_link_properties u_props (.clk(clk), .rst_n(rst_n), .regReadStrobe(regReadStrobe),
    .regWriteStrobe(regWriteStrobe), .regAddr(regAddr), .commMode(commMode), .pwmOut(pwmOut), .pwmOe_n(pwmOe_n));
`default_nettype wire

// ==== sim/mlk_ctrl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********
// Programming controller on the supply line
// ********
module mlk_ctrl_model (
    input wire logic clk, // Clock.
    input wire logic lineIn, // Response wire level.
    output logic supplyOut, // Supply line level.
    output logic respValid, // One-cycle frame done.
    output logic [28:0] respBits // Decoded cells.
);
    int h = 4;
    // Sends n bits MSB first, high half then low for a one; the line idles high after.
    task automatic send(input logic [31:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            supplyOut = bits[i];
            repeat (h) @(negedge clk);
            supplyOut = !bits[i];
            repeat (h) @(negedge clk);
        end
        supplyOut = 1'b1;
    endtask
    // Samples the first half of each cell at its middle, at the rate of the last command.
    // It waits past the frame end so a closing fall is not taken for a new frame.
    initial begin
        supplyOut = 1'b1;
        respValid = 1'b0;
        respBits = '0;
        forever begin
            @(negedge lineIn);
            repeat (h / 2) @(negedge clk);
            for (int k = 0; k < 29; k++) begin
                respBits = {respBits[27:0], lineIn};
                if (k < 28) repeat (2 * h) @(negedge clk);
            end
            repeat (2 * h) @(negedge clk);
            @(posedge clk);
            respValid = 1'b1;
            @(posedge clk);
            respValid = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== sim/mlk_link_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********
// Link bench
// ********
module mlk_link_tb_top;
    import mlk_pkg::*;
    logic clk, rst_n, dataInPin, chipSelectPin, spiModeActive, linkDisable, supplyIn, respValid;
    logic regReadStrobe, regWriteStrobe, commMode, pwmOut, pwmOe_n;
    logic [15:0] regReadData, regWriteData;
    logic [5:0] regAddr;
    logic [28:0] respBits;
    logic [28:0] strbQ[$], respQ[$];
    logic [1:0] myId;
    logic [3:0] own;
    logic lineWire;
    int fail_count = 0;
    int checks_done = 0;
    assign myId = {dataInPin, chipSelectPin};
    assign own = 4'h1 << myId;
    // The pull-up holds the wire high unless the pin pulls low.
    assign lineWire = pwmOe_n ? 1'b1 : pwmOut;
    mlk_link u_dut (.clk(clk), .rst_n(rst_n), .supplyIn(supplyIn), .dataInPin(dataInPin),
        .chipSelectPin(chipSelectPin), .spiModeActive(spiModeActive), .linkDisable(linkDisable),
        .regReadData(regReadData), .regReadStrobe(regReadStrobe), .regWriteStrobe(regWriteStrobe),
        .regAddr(regAddr), .regWriteData(regWriteData), .commMode(commMode), .pwmOut(pwmOut), .pwmOe_n(pwmOe_n));
    mlk_ctrl_model u_ctrl (.clk(clk), .lineIn(lineWire), .supplyOut(supplyIn), .respValid(respValid),
        .respBits(respBits));
    function automatic logic [2:0] crc3(input logic [26:0] b, input int n);
        logic [2:0] c;
        logic f;
        c = 3'h7;
        for (int i = n - 1; i >= 0; i--) begin
            f = c[2] ^ b[i];
            c = {c[1], c[0] ^ f, f};
        end
        return c;
    endfunction
    task automatic check(input logic [28:0] seen, input logic [28:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // A frame carries sync, fields and check; bad flips the last check bit.
    task automatic frame(input logic rw, input logic [3:0] t, input logic [5:0] a, input logic [15:0] d, input logic bad);
        logic [26:0] f;
        int n;
        f = rw ? {16'h0000, rw, t, a} : {rw, t, a, d};
        n = rw ? 11 : 27;
        u_ctrl.send({2'b00, f, crc3(f, n) ^ {2'b00, bad}}, n + 5);
        repeat (4 * u_ctrl.h) @(negedge clk);
    endtask
    task automatic wr(input logic [3:0] t, input logic [5:0] a, input logic [15:0] d, input logic go, input logic bad);
        if (go) strbQ.push_back({7'h01, a, d});
        frame(1'b0, t, a, d, bad);
        repeat (8) @(negedge clk);
    endtask
    // Only one die is read at a time; dup sends a second read during the response.
    task automatic rd(input logic [3:0] t, input logic [5:0] a, input logic go, input logic [2:0] fl, input logic dup);
        logic bc;
        logic [23:0] p;
        bc = (t == 4'h0) || spiModeActive;
        regReadData = 16'($urandom);
        p = {bc ? 2'b00 : myId, bc, fl, regReadData};
        if (go) strbQ.push_back({7'h02, a, 16'h0000});
        if (go) respQ.push_back({2'b00, p, crc3(27'(p), 24)});
        frame(1'b1, t, a, 16'h0000, 1'b0);
        if (dup) frame(1'b1, t, a, 16'h0000, 1'b0);
        repeat (64 * u_ctrl.h) @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Every strobe and every decoded response takes the oldest note of its kind.
    always @(negedge clk) begin
        if (regReadStrobe === 1'b1 || regWriteStrobe === 1'b1)
            check({5'h00, regReadStrobe, regWriteStrobe, regAddr, regWriteData}, strbQ.size() > 0 ? strbQ.pop_front() : 29'bx);
        if (respValid === 1'b1) check(respBits, respQ.size() > 0 ? respQ.pop_front() : 29'bx);
    end
    initial begin
        #1_000_000;
        fail_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(16979));
        rst_n = 1'b0;
        spiModeActive = 1'b0;
        linkDisable = 1'b0;
        regReadData = 16'h0000;
        {dataInPin, chipSelectPin} = 2'($urandom);
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        check(29'(commMode), 29'h0);
        rd(own, 6'h20, 1'b0, 3'h0, 1'b0);
        wr(own, 6'h05, 16'h1234, 1'b0, 1'b0);
        wr(~own, SPECIAL_ADDR, ACCESS_VALUE, 1'b0, 1'b0);
        check(29'(commMode), 29'h1);
        wr(own, 6'h11, 16'ha5c3, 1'b1, 1'b0);
        wr(4'hf, 6'h3e, 16'h8001, 1'b1, 1'b0);
        wr(4'h0, 6'h00, 16'h7ffe, 1'b1, 1'b0);
        wr(~own, 6'h12, 16'h0f0f, 1'b0, 1'b0);
        wr(own, 6'h13, 16'hf0f0, 1'b0, 1'b1);
        rd(own, 6'h20, 1'b1, 3'h1, 1'b0);
        repeat (6) begin
            u_ctrl.h = 2 + $urandom % 7;
            rd(own, 6'($urandom % 63), 1'b1, 3'h0, 1'b0);
        end
        rd(4'h0, 6'h21, 1'b1, 3'h0, 1'b0);
        spiModeActive = 1'b1;
        rd(own, 6'h22, 1'b1, 3'h0, 1'b0);
        spiModeActive = 1'b0;
        u_ctrl.send(32'h0, 7);
        repeat (8 * u_ctrl.h) @(negedge clk);
        rd(own, 6'h23, 1'b1, 3'h4, 1'b1);
        rd(own, 6'h24, 1'b1, 3'h2, 1'b0);
        linkDisable = 1'b1;
        rd(own, 6'h25, 1'b0, 3'h0, 1'b0);
        linkDisable = 1'b0;
        wr(~own, SPECIAL_ADDR, 16'h0000, 1'b0, 1'b0);
        check(29'(commMode), 29'h0);
        rd(own, 6'h20, 1'b0, 3'h0, 1'b0);
        check(29'(respQ.size() + strbQ.size()), 29'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
